// ==== rx_fifo_read_clock_select.sv ====
/*
  Receive phase compensation FIFOs for NCH channels with per-channel
  write and read clock selection, configured over AXI4-Lite.
  Assumes all transceiver-side clocks are levels synchronous to aclk
  and at most half its rate, so every edge is seen as a level change.
*/
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rx_fifo_read_clock_select
  import rx_fifo_clk_pkg::*;
#(
  parameter int unsigned NCH = 4,
  parameter int unsigned DATA_W = 16,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transceiver-side clocks, sampled as levels
  input wire logic [NCH-1:0] tx_pclk,
  input wire logic [NCH-1:0] rec_clk,
  input wire logic core_clk,
  input wire logic master_core_clk,
  input wire logic [NCH-1:0] user_rd_clk,
  // receive pcs data, one word per channel
  input wire logic [NCH*DATA_W-1:0] pcs_data,
  // fabric side
  output logic [NCH*DATA_W-1:0] fab_data,
  output logic [NCH-1:0] fab_valid,
  output logic [NCH-1:0] rd_clk_lvl,
  output logic [NCH-1:0] rm_active
);

  // write side holding registers
  logic aw_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic w_hold_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  // read side
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // configuration and clock history
  logic [CTRL_W-1:0] ctrl_r [NCH];
  logic [NCH-1:0] flush_r;
  logic [NCH-1:0] tx_q_r;
  logic [NCH-1:0] rec_q_r;
  logic [NCH-1:0] usr_q_r;
  logic core_q_r;
  logic mcore_q_r;
  logic [NCH-1:0] wdiv_r;
  logic [NCH-1:0] rdiv_r;
  logic [31:0] stat_w [NCH];

  // write address and data are taken independently, in either order
  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready = ~w_hold_r & ~bvalid_r;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire have_aw = aw_hold_r | aw_take;
  wire have_w = w_hold_r | w_take;
  wire do_write = have_aw & have_w & ~bvalid_r;
  wire [ADDR_W-1:0] wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd = w_hold_r ? wdata_r : s_axi_wdata;
  wire [3:0] ws = w_hold_r ? wstrb_r : s_axi_wstrb;
  wire [CH_W-1:0] wch = wa[CH_W+1:2];
  wire wch_ok = 32'(wch) < NCH;
  wire wr_ctrl = (wa[ADDR_W-1:4] == CTRL_BASE[ADDR_W-1:4]) & wch_ok;
  wire wr_stat = (wa[ADDR_W-1:4] == STAT_BASE[ADDR_W-1:4]) & wch_ok;
  wire wa_bad = |wa[1:0];
  wire wr_ok = (wr_ctrl | wr_stat) & ~wa_bad;

  // write channel handshake and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= '0;
      w_hold_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_hold_r <= have_aw & ~do_write;
      w_hold_r <= have_w & ~do_write;
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // static configuration; a rewrite restarts that channel's fifo
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flush_r <= '0;
      for (int k = 0; k < NCH; k++) begin
        ctrl_r[k] <= CTRL_RST;
      end
    end else begin
      for (int k = 0; k < NCH; k++) begin
        flush_r[k] <= do_write & wr_ok & wr_ctrl & (32'(wch) == k);
        if (do_write && wr_ok && wr_ctrl && (32'(wch) == k)) begin
          if (ws[0]) begin
            ctrl_r[k][7:0] <= wd[7:0];
          end
          if (ws[1]) begin
            ctrl_r[k][15:8] <= wd[15:8];
          end
        end
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  assign s_axi_arready = ~rvalid_r;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [CH_W-1:0] rch = s_axi_araddr[CH_W+1:2];
  wire rch_ok = 32'(rch) < NCH;
  wire ra_ok = ~|s_axi_araddr[1:0];
  wire rd_ctrl = (s_axi_araddr[ADDR_W-1:4] == CTRL_BASE[ADDR_W-1:4]) & rch_ok & ra_ok;
  wire rd_stat = (s_axi_araddr[ADDR_W-1:4] == STAT_BASE[ADDR_W-1:4]) & rch_ok & ra_ok;
  wire [31:0] ctrl_word = rch_ok ? {16'h0000, ctrl_r[rch]} : 32'h0000_0000;
  wire [31:0] stat_word = rch_ok ? stat_w[rch] : 32'h0000_0000;
  wire [31:0] rd_word = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h0000_0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= (rd_ctrl | rd_stat) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // previous clock levels, for rising edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_q_r <= '0;
      rec_q_r <= '0;
      usr_q_r <= '0;
      core_q_r <= 1'b0;
      mcore_q_r <= 1'b0;
    end else begin
      tx_q_r <= tx_pclk;
      rec_q_r <= rec_clk;
      usr_q_r <= user_rd_clk;
      core_q_r <= core_clk;
      mcore_q_r <= master_core_clk;
    end
  end

  wire [NCH-1:0] tx_rise = tx_pclk & ~tx_q_r;
  wire [NCH-1:0] rec_rise = rec_clk & ~rec_q_r;
  wire [NCH-1:0] usr_rise = user_rd_clk & ~usr_q_r;
  wire core_rise = core_clk & ~core_q_r;
  wire mcore_rise = master_core_clk & ~mcore_q_r;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam int unsigned LEAD = i - (i % 2);
    fifo_link_if #(.W(DATA_W)) lnk ();

    cfg_mode_t mode;
    assign mode = cfg_mode_t'(ctrl_r[i][CTRL_MODE_LSB +: 2]);
    wire bser = ctrl_r[i][CTRL_BSER_BIT];
    wire user_en = ctrl_r[i][CTRL_URD_BIT];
    wire bonded = (mode == cfg_x4) || (mode == cfg_x8);
    // identity: same ident tag, same mode and same serializer setting
    wire ident_lead = ({ctrl_r[i][CTRL_IDENT_LSB +: IDENT_W], ctrl_r[i][2:0]}
                    == {ctrl_r[LEAD][CTRL_IDENT_LSB +: IDENT_W], ctrl_r[LEAD][2:0]});
    wire share_lead = (mode == cfg_nb_rm) & ident_lead;
    wire [CH_W-1:0] tx_idx = share_lead ? CH_W'(LEAD) : CH_W'(i);

    // write clock: transmit, recovered or bonded core clock
    wire wr_lvl = (mode == cfg_nb_rm) ? tx_pclk[i] :
                  (mode == cfg_nb_norm) ? rec_clk[i] :
                  (mode == cfg_x4) ? core_clk : master_core_clk;
    wire wr_rise = (mode == cfg_nb_rm) ? tx_rise[i] :
                   (mode == cfg_nb_norm) ? rec_rise[i] :
                   (mode == cfg_x4) ? core_rise : mcore_rise;

    // read clock source; user port wins when enabled
    rd_src_t rsrc;
    assign rsrc = user_en ? src_user_clk :
                  (mode == cfg_nb_rm) ? src_tx_pclk :
                  (mode == cfg_nb_norm) ? src_rec_clk : src_core_clk;
    wire core_lvl = (mode == cfg_x8) ? master_core_clk : core_clk;
    wire core_r = (mode == cfg_x8) ? mcore_rise : core_rise;
    // four-way read clock mux, steered only by static configuration
    assign rd_clk_lvl[i] = (rsrc == src_user_clk) ? user_rd_clk[i] :
                           (rsrc == src_tx_pclk) ? tx_pclk[tx_idx] :
                           (rsrc == src_rec_clk) ? rec_clk[i] : core_lvl;
    wire rd_rise = (rsrc == src_user_clk) ? usr_rise[i] :
                   (rsrc == src_tx_pclk) ? tx_rise[tx_idx] :
                   (rsrc == src_rec_clk) ? rec_rise[i] : core_r;

    // byte serializer halves the parallel clock; user clock is taken as given
    wire halve_rd = bser & (rsrc != src_user_clk);
    assign lnk.wr_pulse = wr_rise & (~bser | wdiv_r[i]);
    assign lnk.rd_pulse = rd_rise & (~halve_rd | rdiv_r[i]);
    assign lnk.wr_data = pcs_data[i*DATA_W +: DATA_W];
    assign lnk.flush = flush_r[i];
    assign lnk.clr_ovf = do_write & wr_ok & wr_stat & (32'(wch) == i) & wd[STAT_OVF_BIT];
    assign lnk.clr_udf = do_write & wr_ok & wr_stat & (32'(wch) == i) & wd[STAT_UDF_BIT];

    // bonded links always carry a rate matcher
    assign rm_active[i] = (mode == cfg_nb_rm) | bonded;
    assign fab_data[i*DATA_W +: DATA_W] = lnk.rd_data;
    assign fab_valid[i] = lnk.rd_valid;

    assign stat_w[i] = {16'h0000, 4'h0, lnk.level, 1'b0, rsrc, ident_lead, rm_active[i],
                        lnk.udf, lnk.ovf, lnk.running};

    // per-channel fifo; an unequal clock pair shows as ovf or udf
    rx_phase_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .lnk(lnk.fifo_end)
    );

    // divide-by-two phase, restarted with the fifo
    always_ff @(posedge aclk) begin
      if (!aresetn || flush_r[i]) begin
        wdiv_r[i] <= 1'b0;
        rdiv_r[i] <= 1'b0;
      end else begin
        if (wr_rise) begin
          wdiv_r[i] <= ~wdiv_r[i];
        end
        if (rd_rise) begin
          rdiv_r[i] <= ~rdiv_r[i];
        end
      end
    end

    wire unused_lvl = wr_lvl;
  end

endmodule : rx_fifo_read_clock_select
`default_nettype wire

// ==== rx_fifo_clk_pkg.sv ====
/*
  Constants, register map and mode types for the receive phase
  compensation FIFO block with read clock selection.
  Assumes a single system clock that oversamples every transceiver-side
  clock, so each clock arrives here as a plain synchronous level.
*/
// Notes on behaviour
// - each receive channel has a FIFO from its PCS write clock to fabric read clock
// - write and read clocks of a channel must run at exactly equal frequency
// - without the user read clock, read clock is chosen from channel configuration
// - channels are identical only with equal reference, PLL, CDR, PMA and PCS settings
// - non-bonded with rate matcher: group reads from lowest channel transmit clock (here: even channel of each pair, when identical to it)
// - non-bonded without rate matcher: each channel reads with its own recovered clock
// - every bonded configuration has a rate matcher in its receive path
// - x4 and x8 bonded channels read with the bonded core clock, x8 from master
// - enabled user read clock bypasses automatic choice and clocks the read side
// - any frequency mismatch overflows or underruns the FIFO, corrupting data
// - non-bonded without rate matcher: write clock is the channel's recovered clock
// - with byte serializer the write clock is halved from the parallel clock
package rx_fifo_clk_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CH_W = 2;
  localparam logic [7:0] CTRL_BASE = 8'h00;
  localparam logic [7:0] STAT_BASE = 8'h10;

  // control word fields, one word per channel
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_BSER_BIT = 2;
  localparam int unsigned CTRL_URD_BIT = 3;
  localparam int unsigned CTRL_IDENT_LSB = 8;
  localparam int unsigned IDENT_W = 8;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  // status word fields, one word per channel
  localparam int unsigned STAT_RUN_BIT = 0;
  localparam int unsigned STAT_OVF_BIT = 1;
  localparam int unsigned STAT_UDF_BIT = 2;
  localparam int unsigned STAT_RM_BIT = 3;
  localparam int unsigned STAT_IDENT_BIT = 4;
  localparam int unsigned STAT_SRC_LSB = 5;
  localparam int unsigned STAT_LVL_LSB = 8;
  localparam int unsigned LVL_W = 4;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // channel configuration, held in the low bits of the control word
  typedef enum logic [1:0] {
    cfg_nb_rm,
    cfg_nb_norm,
    cfg_x4,
    cfg_x8
  } cfg_mode_t;

  // which clock feeds a read side, reported in status
  typedef enum logic [1:0] {
    src_tx_pclk,
    src_rec_clk,
    src_core_clk,
    src_user_clk
  } rd_src_t;

endpackage : rx_fifo_clk_pkg

// ==== fifo_link_if.sv ====
/*
  Bundle between the selection logic and one channel FIFO.
  Assumes pulses are one aclk cycle wide and already qualified.
*/
`timescale 1ns/1ps
`default_nettype none
interface fifo_link_if #(
  parameter int unsigned W = 16
);
  import rx_fifo_clk_pkg::*;
  logic wr_pulse;
  logic [W-1:0] wr_data;
  logic rd_pulse;
  logic flush;
  logic clr_ovf;
  logic clr_udf;
  logic [W-1:0] rd_data;
  logic rd_valid;
  logic running;
  logic ovf;
  logic udf;
  logic [LVL_W-1:0] level;

  modport sel_end (output wr_pulse, wr_data, rd_pulse, flush, clr_ovf, clr_udf,
                   input rd_data, rd_valid, running, ovf, udf, level);
  modport fifo_end (input wr_pulse, wr_data, rd_pulse, flush, clr_ovf, clr_udf,
                    output rd_data, rd_valid, running, ovf, udf, level);
endinterface : fifo_link_if
`default_nettype wire

// ==== rx_phase_fifo.sv ====
/*
  One receive phase compensation FIFO in flip-flops.
  Assumes write and read strobes are edges of the selected clocks,
  sampled on aclk; flush restarts the clock-running detection.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_phase_fifo
  import rx_fifo_clk_pkg::*;
#(
  parameter int unsigned W = 16,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link to the selection logic
  fifo_link_if.fifo_end lnk
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic wseen_r;
  logic rseen_r;
  logic ovf_r;
  logic udf_r;
  logic [W-1:0] rd_data_r;
  logic rd_valid_r;

  // both sides must have ticked before any pointer moves
  wire armed = wseen_r & rseen_r;
  wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty = (wp_r == rp_r);
  wire do_w = armed & lnk.wr_pulse & ~full;
  wire do_r = armed & lnk.rd_pulse & ~empty;
  // a faster write side fills, a faster read side drains dry
  wire ovf_set = armed & lnk.wr_pulse & full;
  wire udf_set = armed & lnk.rd_pulse & empty;

  // pointers and running detection
  always_ff @(posedge aclk) begin
    if (!aresetn || lnk.flush) begin
      wp_r <= '0;
      rp_r <= '0;
      wseen_r <= 1'b0;
      rseen_r <= 1'b0;
    end else begin
      wseen_r <= wseen_r | lnk.wr_pulse;
      rseen_r <= rseen_r | lnk.rd_pulse;
      if (do_w) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_r) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  // sticky error flags; a new event wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_r <= 1'b0;
      udf_r <= 1'b0;
    end else begin
      ovf_r <= ovf_set | (ovf_r & ~lnk.clr_ovf);
      udf_r <= udf_set | (udf_r & ~lnk.clr_udf);
    end
  end

  // storage has no reset, only valid entries are ever read
  always_ff @(posedge aclk) begin
    if (do_w) begin
      mem_r[wp_r[AW-1:0]] <= lnk.wr_data;
    end
  end

  // registered read data toward the fabric
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= do_r;
      if (do_r) begin
        rd_data_r <= mem_r[rp_r[AW-1:0]];
      end
    end
  end

  assign lnk.rd_data = rd_data_r;
  assign lnk.rd_valid = rd_valid_r;
  assign lnk.running = armed;
  assign lnk.ovf = ovf_r;
  assign lnk.udf = udf_r;
  assign lnk.level = LVL_W'(wp_r - rp_r);

endmodule : rx_phase_fifo
`default_nettype wire

// ==== rx_fifo_sva.sv ====
/*
  Checker for the receive fifo clock select top: bus handshakes, ch0 read path.
  Assumes one aclk domain; bound onto the top module below.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_fifo_sva
  import rx_fifo_clk_pkg::*;
#(
  parameter int unsigned NCH = 4,
  parameter int unsigned DATA_W = 16,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // fabric side
  input wire logic [NCH*DATA_W-1:0] fab_data,
  input wire logic [NCH-1:0] fab_valid,
  input wire logic [NCH-1:0] rd_clk_lvl
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // answers stand until the master takes them
  chk_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_r_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  chk_aw_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_w_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // read strobes come only from a rising edge of the selected read clock
  chk_fab_cause: assert property (
    fab_valid[0] |-> $past(rd_clk_lvl[0]) && !$past(rd_clk_lvl[0], 2))
    else $error("fabric word without read clock edge");
  chk_fab_pulse: assert property (fab_valid[0] |=> !fab_valid[0])
    else $error("fabric valid wider than one cycle");
  chk_data_hold: assert property ($changed(fab_data[DATA_W-1:0]) |-> fab_valid[0])
    else $error("fabric data moved without a read");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (fab_valid[0]);
endmodule : rx_fifo_sva

bind rx_fifo_read_clock_select rx_fifo_sva #(.NCH(NCH), .DATA_W(DATA_W), .DEPTH(DEPTH)) i_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fab_data(fab_data),
  .fab_valid(fab_valid), .rd_clk_lvl(rd_clk_lvl));
`default_nettype wire

// ==== fabric_sink.sv ====
/*
  Fabric user logic model: captures channel 0 words on its read strobe.
  Assumes the strobe is already in the read clock's domain.
*/
`timescale 1ns/1ps
`default_nettype none
module fabric_sink #(
  parameter int unsigned DATA_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // channel 0 fabric side
  input wire logic [DATA_W-1:0] word,
  input wire logic strobe,
  // what was captured
  output var int count,
  output logic [DATA_W-1:0] last
);
  // capture on aclk only while the strobe is high, never between strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 0;
      last <= '0;
    end else if (strobe) begin
      count <= count + 1;
      last <= word;
    end
  end
endmodule : fabric_sink
`default_nettype wire

// ==== test_rx_fifo_read_clock_select.sv ====
/*
  Testbench: bus tasks, clock-source table per mode, channel 0 data path.
  Assumes transceiver clocks are slow levels driven here, synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_rx_fifo_read_clock_select;
  import rx_fifo_clk_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf, tx_pclk = 4'h0, rec_clk = 4'h0, user_rd_clk = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, core_clk = 1'b0, master_core_clk = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [63:0] pcs_data = 64'h0, fab_data;
  logic [3:0] fab_valid, rd_clk_lvl, rm_active;
  logic [15:0] last;
  int count, mismatches = 0, checked = 0, i, base;
  // per mode of ch1: control word, expected {source, identical, rate matcher}, clock source
  logic [15:0] cfg_tab [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0008, 16'h0100};
  logic [3:0] exp_tab [6] = '{4'h3, 4'h4, 4'h9, 4'h9, 4'hf, 4'h1};
  int src_tab [6] = '{0, 1, 2, 3, 4, 0};
  int ch_tab [6] = '{0, 1, 1, 1, 1, 1};

  always #25 aclk = ~aclk;

  rx_fifo_read_clock_select i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_pclk(tx_pclk),
    .rec_clk(rec_clk), .core_clk(core_clk), .master_core_clk(master_core_clk),
    .user_rd_clk(user_rd_clk), .pcs_data(pcs_data), .fab_data(fab_data),
    .fab_valid(fab_valid), .rd_clk_lvl(rd_clk_lvl), .rm_active(rm_active));

  fabric_sink i_sink (.aclk(aclk), .aresetn(aresetn), .word(fab_data[15:0]),
    .strobe(fab_valid[0]), .count(count), .last(last));

  task test_done;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  // write: handshakes judged at the falling edge, released after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, hb;
    hb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, hr;
    hr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd

  // one source (by table code) at v, all others opposite; one assignment per signal
  task automatic lv(input int s, input int ch, input logic v);
    logic [3:0] one;
    one = 4'h1 << ch;
    tx_pclk <= {4{~v}} ^ ((s == 0) ? one : 4'h0);
    rec_clk <= {4{~v}} ^ ((s == 1) ? one : 4'h0);
    core_clk <= ~v ^ (s == 2);
    master_core_clk <= ~v ^ (s == 3);
    user_rd_clk <= {4{~v}} ^ ((s >= 4) ? one : 4'h0);
  endtask : lv

  task automatic all_lv(input logic v);
    tx_pclk <= {4{v}};
    rec_clk <= {4{v}};
    core_clk <= v;
    master_core_clk <= v;
    user_rd_clk <= {4{v}};
  endtask : all_lv

  // one edge on ch0 write and/or user read clock, levels held two cycles
  task automatic pulse(input bit w, input bit rr);
    @(posedge aclk);
    if (w) tx_pclk[0] <= 1'b1;
    if (rr) user_rd_clk[0] <= 1'b1; // same rate as the write clock
    repeat (2) @(posedge aclk);
    tx_pclk[0] <= 1'b0;
    user_rd_clk[0] <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : pulse

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, d, r);
    `CHK("ctrl0 reset", 32'h0, d)
    rd(8'h14, d, r);
    `CHK("stat1 reset", 32'h18, d)
    rd(8'h20, d, r);
    `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {r, d})
    wr(8'h02, 32'h1, r);
    `CHK("unaligned write", RESP_SLVERR, r)
    $display("test map done");
    // every mode of ch1 against its status and its selected read clock
    for (i = 0; i < 6; i++) begin
      wr(8'h04, {16'h0, cfg_tab[i]}, r);
      rd(8'h14, d, r);
      `CHK("stat1 source", exp_tab[i][3:2], d[6:5])
      `CHK("stat1 ident rm", exp_tab[i][1:0], d[4:3])
      `CHK("rm_active", exp_tab[i][0], rm_active[1])
      lv(src_tab[i], ch_tab[i], 1'b1);
      repeat (2) @(posedge aclk);
      `CHK("read clock high", 1'b1, rd_clk_lvl[1])
      lv(src_tab[i], ch_tab[i], 1'b0);
      repeat (2) @(posedge aclk);
      `CHK("read clock low", 1'b0, rd_clk_lvl[1])
      all_lv(1'b0);
    end
    $display("test modes done");
    // ch0: automatic write clock, user read clock; the mode sweep left words and
    // flags behind, so clear the flags and count sink words from here on
    wr(8'h00, 32'h8, r);
    wr(8'h10, 32'h6, r);
    base = count;
    pulse(1, 1);
    rd(8'h10, d, r);
    `CHK("running", 1'b1, d[0])
    for (i = 0; i < 3; i++) begin
      pcs_data <= {48'h0, 16'ha000 + 16'(i)};
      pulse(1, 0);
    end
    for (i = 0; i < 3; i++) begin
      pulse(0, 1);
      `CHK("word", 16'ha000 + 16'(i), last)
    end
    pulse(0, 1);
    `CHK("no word when empty", 3, count - base)
    rd(8'h10, d, r);
    `CHK("underrun stat", 32'h7d, d)
    wr(8'h10, 32'h4, r);
    rd(8'h10, d, r);
    `CHK("underrun cleared", 32'h79, d)
    for (i = 0; i < 9; i++) begin
      pcs_data <= {48'h0, 16'hb000 + 16'(i)};
      pulse(1, 0);
    end
    rd(8'h10, d, r);
    `CHK("overflow stat", 32'h87b, d)
    for (i = 0; i < 8; i++) begin
      pulse(0, 1);
      `CHK("word after overflow", 16'hb000 + 16'(i), last)
    end
    `CHK("word count", 11, count - base)
    // byte serializer: only every second write edge counts, so c003 is the one stored
    wr(8'h00, 32'hc, r);
    for (i = 0; i < 5; i++) begin
      pcs_data <= {48'h0, 16'hc000 + 16'(i)};
      pulse(i < 4, i == 0 || i == 4);
    end
    `CHK("halved write clock", 16'hc003, last)
    `CHK("halved word count", 12, count - base)
    $display("test data path done");
    test_done();
  end
endmodule : test_rx_fifo_read_clock_select
`undef CHK
`default_nettype wire
